/* File: pbs_mode_ctl.sv */
// test mode controller: decodes the two mode pins into functional,
// scan normal and scan shift states
// assumes mode pins are synchronous to clk_i
`include "pbs_params.svh"

module pbs_mode_ctl (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic boundary_scan_select_i,
   input wire logic shift_select_i,
   output pbs_pkg::pbs_state_type state_o,
   output pbs_pkg::pbs_state_type next_state_o,
   output logic reserved_mode_o
);

   // pin decode; the reserved code is treated as functional operation
   wire logic scan_sel = boundary_scan_select_i;
   wire logic shift_sel = shift_select_i;
   assign reserved_mode_o = !scan_sel && shift_sel;
   assign next_state_o = !scan_sel ? pbs_pkg::PBS_FUNC :
                         shift_sel ? pbs_pkg::PBS_SCAN_SHIFT :
                         pbs_pkg::PBS_SCAN_NORM;

   // reset acts only when scan is not requested, so entry works under reset
   always_ff @(posedge clk_i) begin
      if (reset_i && !scan_sel) begin
         state_o <= pbs_pkg::PBS_FUNC;
      end else begin
         state_o <= next_state_o;
      end
   end

endmodule // pbs_mode_ctl

/* File: pbs_params.svh */
// constants for the pin boundary scan logic: widths, state codes, chain size
// assumes inclusion by bare name from the package and the design modules
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// pin group widths
`define PBS_DATA_W 64
`define PBS_ADDR_W 29
`define PBS_BE_W 8
`define PBS_CC_W 2

// one-hot state codes of the test mode controller
`define PBS_ST_FUNC 3'h1
`define PBS_ST_SCAN_NORM 3'h2
`define PBS_ST_SCAN_SHIFT 3'h4

// total latch count: 64+1+29+1+8+1+1+1+1+1+1 outputs/controls, 11 input latches
`define PBS_CHAIN_W 120

`endif

/* File: pbs_pkg.sv */
// types for the pin boundary scan logic
// assumes pbs_params.svh is on the include path
`include "pbs_params.svh"

package pbs_pkg;

   // test mode controller states
   typedef enum logic [2:0] {
      PBS_FUNC = `PBS_ST_FUNC,
      PBS_SCAN_NORM = `PBS_ST_SCAN_NORM,
      PBS_SCAN_SHIFT = `PBS_ST_SCAN_SHIFT
   } pbs_state_type;

   // values and enables for the floatable output pins and buses
   typedef struct packed {
      logic [`PBS_DATA_W-1:0] data;
      logic data_oe;
      logic [`PBS_ADDR_W-1:0] addr;
      logic addr_oe;
      logic [`PBS_BE_W-1:0] byte_enables;
      logic byte_enables_oe;
      logic next_near_out;
      logic next_near_oe;
      logic page_table_bit_out;
      logic page_table_bit_oe;
   } pbs_drive_type;

   // levels seen at the pads, inputs and the receivers of outputs alike
   typedef struct packed {
      logic [`PBS_DATA_W-1:0] data;
      logic [`PBS_ADDR_W-1:0] addr;
      logic [`PBS_BE_W-1:0] byte_enables;
      logic next_near_out;
      logic page_table_bit_out;
      logic ready;
      logic cache_enable_in;
      logic next_address_in;
      logic interrupt;
      logic hold;
      logic [`PBS_CC_W-1:0] cache_ctl;
   } pbs_sense_type;

   // the latch chain, first field nearest bus_request_out, last nearest scan_serial_in
   typedef struct packed {
      logic bus_request;
      logic [`PBS_BE_W-1:0] byte_enables;
      logic byte_enables_ctl;
      logic page_table_bit;
      logic page_table_bit_ctl;
      logic next_near;
      logic next_near_ctl;
      logic [`PBS_ADDR_W-1:0] addr;
      logic addr_ctl;
      logic [`PBS_DATA_W-1:0] data;
      logic data_ctl;
      logic hold;
      logic interrupt;
      logic next_address;
      logic cache_enable;
      logic ready;
      logic [`PBS_CC_W-1:0] cache_ctl;
      logic reset;
      logic shift_select;
      logic scan_select;
      logic serial_in;
   } pbs_chain_type;

endpackage : pbs_pkg

/* File: pbs_tester.sv */
// board test equipment model: mode pins, reset and the serial pair
// assumes it changes its pins only at falling clock edges
`include "pbs_params.svh"
module pbs_tester (
   input wire logic clk_i,
   input wire logic bus_request_out_i,
   output logic reset_o,
   output logic boundary_scan_select_o,
   output logic shift_select_o,
   output logic scan_serial_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // only clock, reset, two selects and the serial pair reach the pins
   initial begin
      reset_o = 1'b1;
      boundary_scan_select_o = 1'b0;
      shift_select_o = 1'b0;
      scan_serial_in_o = 1'b0;
   end
   // one edge in the requested mode; reset after a session re-inits
   task automatic set_mode(input logic sel, input logic sh, input logic rst);
      @(negedge clk_i);
      boundary_scan_select_o = sel;
      shift_select_o = sh;
      reset_o = rst;
      @(posedge clk_i);
   endtask
   // first bit out is already shown, so sample before each shift edge
   task automatic shift_bits(input logic [`PBS_CHAIN_W-1:0] din,
                             output logic [`PBS_CHAIN_W-1:0] dout);
      for (int i = `PBS_CHAIN_W - 1; i >= 0; i--) begin
         @(negedge clk_i);
         scan_serial_in_o = din[i];
         dout[i] = bus_request_out_i;
         @(posedge clk_i);
      end
   endtask
endmodule // pbs_tester

/* File: pbs_top.sv */
// pin boundary scan logic sitting between the processor core and its pads
// assumes all pins synchronous to clk_i; the pad ring resolves each
// floatable pin from its value and enable
//
// Summary of operation
// - scan select sampled high enters scan next cycle
// - scan entry accepted while reset is held
// - scan select sampled low leaves scan next cycle
// - processor state undefined after leaving scan
// - pins decode: off, reserved, normal, shift
// - shift select picks shift or normal sub-mode
// - latch per pin except clock and hold acknowledge, control latch per floatable output group
// - normal sub-mode drives latches where control set
// - shift entry captures every latched pin at once
// - forced output latches keep their value on capture
// - bus request latch appears right after shift entry
// - each later shift clock moves chain one place
// - shift floats all but hold acknowledge, bus request
// - chain covers listed inputs, outputs and controls
`include "pbs_params.svh"

module pbs_top (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic boundary_scan_select_i,
   input wire logic shift_select_i,
   input wire logic scan_serial_in_i,
   input wire pbs_pkg::pbs_drive_type core_drive_i,
   input wire logic core_bus_request_i,
   input wire logic core_hold_ack_i,
   input wire pbs_pkg::pbs_sense_type pad_sense_i,
   output pbs_pkg::pbs_drive_type pad_drive_o,
   output logic bus_request_out_o,
   output logic hold_acknowledge_out_o,
   output logic scan_active_o,
   output logic reserved_mode_o
);

   localparam int CHAIN_W = $bits(pbs_pkg::pbs_chain_type);

   pbs_pkg::pbs_state_type state;
   pbs_pkg::pbs_state_type next_state;
   logic reserved_mode;
   pbs_pkg::pbs_chain_type chain;
   pbs_pkg::pbs_chain_type next_chain;
   pbs_pkg::pbs_chain_type captured;
   pbs_pkg::pbs_chain_type shifted;
   pbs_pkg::pbs_drive_type forced;
   pbs_pkg::pbs_drive_type next_drive;
   logic next_bus_request;
   logic keep_forced;
   logic shift_entry;
   logic shift_step;
   logic in_norm_next;
   logic in_shift_next;
   logic in_func_next;
   logic keep_data;
   logic keep_addr;
   logic keep_byte_enables;
   logic keep_next_near;
   logic keep_page_table_bit;
   logic [CHAIN_W-1:0] chain_bits;
   wire logic [CHAIN_W-1:0] shifted_bits;

   // mode pins to state
   pbs_mode_ctl u_mode_ctl (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .boundary_scan_select_i(boundary_scan_select_i),
      .shift_select_i(shift_select_i),
      .state_o(state),
      .next_state_o(next_state),
      .reserved_mode_o(reserved_mode)
   );

   // state qualifiers used by chain and pad selection
   assign in_func_next = (next_state == pbs_pkg::PBS_FUNC);
   assign in_norm_next = (next_state == pbs_pkg::PBS_SCAN_NORM);
   assign in_shift_next = (next_state == pbs_pkg::PBS_SCAN_SHIFT);
   assign shift_entry = in_shift_next && (state != pbs_pkg::PBS_SCAN_SHIFT);
   assign shift_step = in_shift_next && (state == pbs_pkg::PBS_SCAN_SHIFT);

   // forcing only counts if the pins were really driven from the latches
   assign keep_forced = (state == pbs_pkg::PBS_SCAN_NORM);

   // per group: a latch keeps its value only if it really drove its pins
   assign keep_data = keep_forced && chain.data_ctl;
   assign keep_addr = keep_forced && chain.addr_ctl;
   assign keep_byte_enables = keep_forced && chain.byte_enables_ctl;
   assign keep_next_near = keep_forced && chain.next_near_ctl;
   assign keep_page_table_bit = keep_forced && chain.page_table_bit_ctl;

   // capture of output pins: a driven pin keeps its latch, a floated one
   // reads what the board puts on it
   assign captured.data = keep_data ? chain.data : pad_sense_i.data;
   assign captured.addr = keep_addr ? chain.addr : pad_sense_i.addr;
   assign captured.byte_enables = keep_byte_enables ?
                                  chain.byte_enables :
                                  pad_sense_i.byte_enables;
   assign captured.next_near = keep_next_near ?
                               chain.next_near : pad_sense_i.next_near_out;
   assign captured.page_table_bit = keep_page_table_bit ?
                                    chain.page_table_bit :
                                    pad_sense_i.page_table_bit_out;

   // bus request is never floated, so its own driven level is the pin level
   assign captured.bus_request = keep_forced ? chain.bus_request : bus_request_out_o;

   // control latches have no pin and simply hold
   assign captured.data_ctl = chain.data_ctl;
   assign captured.addr_ctl = chain.addr_ctl;
   assign captured.byte_enables_ctl = chain.byte_enables_ctl;
   assign captured.next_near_ctl = chain.next_near_ctl;
   assign captured.page_table_bit_ctl = chain.page_table_bit_ctl;

   // input latches take the externally driven levels
   assign captured.hold = pad_sense_i.hold;
   assign captured.interrupt = pad_sense_i.interrupt;
   assign captured.next_address = pad_sense_i.next_address_in;
   assign captured.cache_enable = pad_sense_i.cache_enable_in;
   assign captured.ready = pad_sense_i.ready;
   assign captured.cache_ctl = pad_sense_i.cache_ctl;
   assign captured.reset = reset_i;
   assign captured.shift_select = shift_select_i;
   assign captured.scan_select = boundary_scan_select_i;
   assign captured.serial_in = scan_serial_in_i;

   // serial order as published to testers, bit 119 nearest bus_request_out;
   // a tester shifts bit 119 in first and also reads it out first
   // bit 119: bus_request
   // bits 118:111: byte_enables 7 down to 0
   // bit 110: byte_enables control
   // bit 109: page_table_bit_out
   // bit 108: page_table_bit_out control
   // bit 107: next_near_out
   // bit 106: next_near_out control
   // bits 105:77: address 28 down to 0
   // bit 76: address control
   // bits 75:12: data 63 down to 0
   // bit 11: data control
   // bit 10: hold input
   // bit 9: interrupt input
   // bit 8: next_address_in
   // bit 7: cache_enable_in
   // bit 6: ready input
   // bits 5:4: cache control inputs 1 down to 0
   // bit 3: reset input
   // bit 2: shift_select input
   // bit 1: boundary_scan_select input
   // bit 0: scan_serial_in
   // a full load or unload takes one shift clock per latch

   // one place toward bus_request_out per clock, new bit at the far end
   assign chain_bits = chain;
   for (genvar i = 0; i < CHAIN_W; i++) begin : g_shift
      if (i == 0) begin : g_first
         assign shifted_bits[i] = scan_serial_in_i;
      end else begin : g_next
         assign shifted_bits[i] = chain_bits[i-1];
      end
   end
   assign shifted = pbs_pkg::pbs_chain_type'(shifted_bits);

   // chain next value: capture wins on entry, shift on later clocks
   assign next_chain = shift_entry ? captured :
                       shift_step ? shifted :
                       chain;

   // latch chain; cleared by reset only outside scan so entry under
   // reset does not lose a pattern being loaded
   always_ff @(posedge clk_i) begin
      if (reset_i && !boundary_scan_select_i) begin
         chain <= pbs_pkg::pbs_chain_type'('0);
      end else begin
         chain <= next_chain;
      end
   end

   // latch values mapped onto pin groups, enables from control latches
   assign forced.data = next_chain.data;
   assign forced.data_oe = next_chain.data_ctl;
   assign forced.addr = next_chain.addr;
   assign forced.addr_oe = next_chain.addr_ctl;
   assign forced.byte_enables = next_chain.byte_enables;
   assign forced.byte_enables_oe = next_chain.byte_enables_ctl;
   assign forced.next_near_out = next_chain.next_near;
   assign forced.next_near_oe = next_chain.next_near_ctl;
   assign forced.page_table_bit_out = next_chain.page_table_bit;
   assign forced.page_table_bit_oe = next_chain.page_table_bit_ctl;

   // pad selection: core in functional use, latches in normal scan,
   // everything floated while shifting to avoid glitches
   always_comb begin
      next_drive = core_drive_i;
      if (in_norm_next) begin
         next_drive = forced;
      end else if (in_shift_next) begin
         next_drive = forced;
         next_drive.data_oe = 1'h0;
         next_drive.addr_oe = 1'h0;
         next_drive.byte_enables_oe = 1'h0;
         next_drive.next_near_oe = 1'h0;
         next_drive.page_table_bit_oe = 1'h0;
      end
   end

   // bus request doubles as the serial output while shifting
   assign next_bus_request = in_func_next ? core_bus_request_i :
                             next_chain.bus_request;

   // output flops; pads follow the core one clock late, the price of
   // registered outputs on every pin
   always_ff @(posedge clk_i) begin
      if (reset_i && !boundary_scan_select_i) begin
         pad_drive_o <= pbs_pkg::pbs_drive_type'('0);
         bus_request_out_o <= 1'h0;
      end else begin
         pad_drive_o <= next_drive;
         bus_request_out_o <= next_bus_request;
      end
   end

   // hold acknowledge stays driven in every mode and may glitch in scan
   always_ff @(posedge clk_i) begin
      if (reset_i && !boundary_scan_select_i) begin
         hold_acknowledge_out_o <= 1'h0;
      end else begin
         hold_acknowledge_out_o <= core_hold_ack_i;
      end
   end

   // tells the core its state is lost; it needs a reset after the session
   always_ff @(posedge clk_i) begin
      if (reset_i && !boundary_scan_select_i) begin
         scan_active_o <= 1'h0;
         reserved_mode_o <= 1'h0;
      end else begin
         scan_active_o <= !in_func_next;
         reserved_mode_o <= reserved_mode;
      end
   end

endmodule // pbs_top

/* File: pbs_top_assertions.sv */
// concurrent checks on the pin boundary scan top level ports
// assumes one clock domain and a sync reset that scan select overrides
module pbs_top_checker (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic boundary_scan_select_i,
   input wire logic shift_select_i,
   input wire logic scan_serial_in_i,
   input wire pbs_pkg::pbs_drive_type core_drive_i,
   input wire logic core_bus_request_i,
   input wire logic core_hold_ack_i,
   input wire pbs_pkg::pbs_sense_type pad_sense_i,
   input wire pbs_pkg::pbs_drive_type pad_drive_o,
   input wire logic bus_request_out_o,
   input wire logic hold_acknowledge_out_o,
   input wire logic scan_active_o,
   input wire logic reserved_mode_o
);
   logic [7:0] shift_run;
   wire logic in_shift = boundary_scan_select_i && shift_select_i;
   wire logic in_norm = boundary_scan_select_i && !shift_select_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i && !boundary_scan_select_i);
   // consecutive shift edges; saturates so long runs stay valid
   always_ff @(posedge clk_i) begin
      if ((reset_i && !boundary_scan_select_i) || !in_shift) begin
         shift_run <= 8'h0;
      end else if (shift_run != 8'hff) begin
         shift_run <= shift_run + 8'h1;
      end
   end
   scan_enter_a: assert property (boundary_scan_select_i |=> scan_active_o)
      else $error("scan mode not entered");
   scan_exit_a: assert property (!boundary_scan_select_i |=> !scan_active_o
      && pad_drive_o == $past(core_drive_i) && bus_request_out_o == $past(core_bus_request_i))
      else $error("functional path wrong after scan select low");
   mode_decode_a: assert property (1 |=>
      reserved_mode_o == $past(!boundary_scan_select_i && shift_select_i))
      else $error("reserved code flag wrong");
   hold_ack_a: assert property (1 |=> hold_acknowledge_out_o == $past(core_hold_ack_i))
      else $error("hold acknowledge does not follow core");
   shift_float_a: assert property (in_shift |=> !(pad_drive_o.data_oe ||
      pad_drive_o.addr_oe || pad_drive_o.byte_enables_oe || pad_drive_o.next_near_oe
      || pad_drive_o.page_table_bit_oe)) else $error("pad driven in shift");
   chain_move_a: assert property (shift_run >= 8'h79 |->
      bus_request_out_o == $past(scan_serial_in_i, 120))
      else $error("serial bit not out after chain length");
   shift_entry_a: assert property (in_shift && !$past(in_shift) |=>
      bus_request_out_o == $past(bus_request_out_o))
      else $error("bus request latch not shown at shift entry");
   normal_hold_a: assert property ($past(in_norm) && $past(in_norm, 2) |->
      $stable(pad_drive_o)) else $error("forced pads moved in normal");
endmodule // pbs_top_checker

bind pbs_top pbs_top_checker u_checker (.clk_i, .reset_i, .boundary_scan_select_i,
   .shift_select_i, .scan_serial_in_i, .core_drive_i, .core_bus_request_i, .core_hold_ack_i,
   .pad_sense_i, .pad_drive_o, .bus_request_out_o, .hold_acknowledge_out_o, .scan_active_o,
   .reserved_mode_o);

/* File: pbs_top_tb.sv */
// self-checking bench for the pin boundary scan top level
// assumes pbs_tester plays the board tester; the bench plays core and pads
`include "pbs_params.svh"
module pbs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam pbs_pkg::pbs_drive_type PAT = 108'h123_4567_89ab_cdef_0246_8ace_1357;
   localparam pbs_pkg::pbs_sense_type PS = 110'h2d_b6db_6d3c_a5f0_0ff0_1234_abcd;
   logic clk_i = 1'b0;
   logic reset_i, boundary_scan_select_i, shift_select_i, scan_serial_in_i;
   logic core_bus_request_i, core_hold_ack_i, bus_request_out_o, hold_acknowledge_out_o;
   logic scan_active_o, reserved_mode_o;
   pbs_pkg::pbs_drive_type core_drive_i, pad_drive_o;
   pbs_pkg::pbs_sense_type pad_sense_i;
   pbs_pkg::pbs_chain_type load, exp;
   logic [`PBS_CHAIN_W-1:0] seen;
   int mismatches = 0;
   int checked = 0;
   always #2 clk_i = ~clk_i;
   pbs_top dut (.clk_i, .reset_i, .boundary_scan_select_i, .shift_select_i, .scan_serial_in_i,
      .core_drive_i, .core_bus_request_i, .core_hold_ack_i, .pad_sense_i, .pad_drive_o,
      .bus_request_out_o, .hold_acknowledge_out_o, .scan_active_o, .reserved_mode_o);
   pbs_tester tester (.clk_i, .bus_request_out_i(bus_request_out_o), .reset_o(reset_i),
      .boundary_scan_select_o(boundary_scan_select_i), .shift_select_o(shift_select_i),
      .scan_serial_in_o(scan_serial_in_i));
   task automatic check(input string what, input logic [127:0] got, input logic [127:0] want);
      checked++;
      if (got !== want) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, want, got);
      end
   endtask
   task automatic drive_core(input pbs_pkg::pbs_drive_type d, input logic br, input logic ha);
      @(negedge clk_i);
      core_drive_i = d;
      core_bus_request_i = br;
      core_hold_ack_i = ha;
   endtask
   // plain and reserved codes both run the functional path
   task automatic t_func;
      drive_core(PAT, 1'b1, 1'b1);
      tester.set_mode(1'b0, 1'b0, 1'b0);
      #1;
      check("func pads", {pad_drive_o, bus_request_out_o}, {PAT, 1'b1});
      tester.set_mode(1'b0, 1'b1, 1'b0);
      #1;
      check("reserved", {reserved_mode_o, scan_active_o, pad_drive_o}, {2'b10, PAT});
   endtask
   // enter under reset, load, force, capture and read the whole chain
   task automatic t_scan;
      load = pbs_pkg::pbs_chain_type'(120'h12_3456_789a_bcde_f0f0_5a5a_c3c3_9696);
      {load.bus_request, load.next_near, load.data_ctl, load.byte_enables_ctl} = 4'hf;
      {load.next_near_ctl, load.addr_ctl, load.page_table_bit_ctl, load.reset} = 4'h9;
      tester.set_mode(1'b1, 1'b0, 1'b1);
      #1;
      check("scan under reset", scan_active_o, 1'b1);
      tester.set_mode(1'b1, 1'b1, 1'b0);
      tester.shift_bits(load, seen);
      // first capture came from normal scan with every control latch clear
      exp = pbs_pkg::pbs_chain_type'('0);
      {exp.data, exp.addr, exp.byte_enables, exp.next_near, exp.page_table_bit} =
         {PS.data, PS.addr, PS.byte_enables, PS.next_near_out, PS.page_table_bit_out};
      {exp.hold, exp.interrupt, exp.next_address, exp.cache_enable, exp.ready, exp.cache_ctl} =
         {PS.hold, PS.interrupt, PS.next_address_in, PS.cache_enable_in, PS.ready, PS.cache_ctl};
      {exp.shift_select, exp.scan_select} = 2'b11;
      check("floated capture", seen, exp);
      tester.set_mode(1'b1, 1'b0, 1'b0);
      #1;
      check("forced pads",
         {pad_drive_o.data, pad_drive_o.data_oe, pad_drive_o.addr_oe,
         pad_drive_o.byte_enables, pad_drive_o.byte_enables_oe, pad_drive_o.next_near_out,
         pad_drive_o.next_near_oe, pad_drive_o.page_table_bit_oe, bus_request_out_o},
         {load.data, 2'b10, load.byte_enables, 2'b11, 3'b101});
      exp = load;
      exp.addr = PS.addr;
      exp.page_table_bit = PS.page_table_bit_out;
      {exp.hold, exp.interrupt, exp.next_address, exp.cache_enable, exp.ready, exp.cache_ctl} =
         {PS.hold, PS.interrupt, PS.next_address_in, PS.cache_enable_in, PS.ready, PS.cache_ctl};
      {exp.reset, exp.shift_select, exp.scan_select} = 3'b011;
      drive_core(~PAT, 1'b0, 1'b0);
      tester.set_mode(1'b1, 1'b1, 1'b0);
      #1;
      check("shift entry",
         {pad_drive_o.data_oe, pad_drive_o.addr_oe, pad_drive_o.next_near_oe,
         pad_drive_o.byte_enables_oe, pad_drive_o.page_table_bit_oe, bus_request_out_o,
         hold_acknowledge_out_o}, 7'h02);
      tester.shift_bits('0, seen);
      check("captured chain", seen, exp);
   endtask
   // leaving scan returns pads to the core; reset then clears them
   task automatic t_exit;
      drive_core(PAT, 1'b1, 1'b1);
      tester.set_mode(1'b0, 1'b0, 1'b0);
      #1;
      check("exit", {scan_active_o, pad_drive_o}, {1'b0, PAT});
      tester.set_mode(1'b0, 1'b0, 1'b1);
      #1;
      check("reinit", {pad_drive_o, bus_request_out_o, scan_active_o}, '0);
   endtask
   task automatic print_verdict;
      if (mismatches == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      core_drive_i = '0;
      core_bus_request_i = 1'b0;
      core_hold_ack_i = 1'b0;
      pad_sense_i = PS;
      repeat (5) tester.set_mode(1'b0, 1'b0, 1'b1);
      t_func();
      t_scan();
      t_exit();
      print_verdict();
   end
   // about 257 cycles expected; cut a hang well beyond that
   initial begin
      #20000;
      mismatches++;
      print_verdict();
   end
endmodule // pbs_top_tb
